/* logic/cpam_monitor.sv */
/*
  Critical parameter alarm monitor: APB register file, limit checks on
  each measurement sample, driver fault inputs, alarm state and motor
  shutdown outputs. Assumes measurements arrive with a one-cycle
  sample strobe and that the STOP command arrives as a one-cycle pulse.
*/
// Contract
// - Any out-of-range current, voltage or temperature halts motion, de-energizes, alarms.
// - Alarm leaves only when values are normal and STOP arrives.
// - Same limit checks for stepper and DC motor types.
// - Undervoltage threshold in 10 mV, checked only when its enable is set.
// - Trip when supply current exceeds the mA maximum.
// - Trip when supply voltage exceeds the 10 mV maximum.
// - Trip when processor temperature exceeds the 0.1 degC maximum.
// - Driver overheat warning alarms when its enable is set.
// - Power stage fault alarms when its enable is set.
// - Limit switch against travel direction alarms when its enable is set.
// - Sticky flag latches cause indicators; otherwise they follow the cause.
// - Link-loss recovery unit runs only while its enable is set.
// - Alarm entry drops winding current at once, no ramp.
// - Alarm blocks motion, rejects moves, shows readable alarm flag.
`timescale 1ns/1ps
`default_nettype none

module cpam_monitor
  import cpam_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic motor_is_dc,
  input wire logic sample_valid,
  input wire cpam_meas_s meas,
  input wire cpam_drv_s drv,
  input wire logic stop_cmd,
  input wire logic move_req,
  input wire logic link_activity,
  output logic move_accept,
  output logic motion_halt,
  output logic winding_off,
  output logic ramp_bypass,
  output logic alarm,
  output logic link_reconnect
);

  // ==========================================================
  // Functions
  // ==========================================================
  // Unsigned exceed test, shared by the voltage and current maximum limits
  function automatic logic over_u(input logic [15:0] v, input logic [15:0] lim);
    over_u = v > lim;
  endfunction : over_u

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = a == r;
  endfunction : hit

  // ==========================================================
  // Registers
  // ==========================================================
  logic [CPAM_CTRL_W-1:0] ctrl;
  logic [15:0] low_v;
  logic [15:0] max_i;
  logic [15:0] max_v;
  logic [15:0] max_t;
  cpam_meas_s meas_q;
  logic [CPAM_NCAUSE-1:0] cause;
  cpam_state_e state;
  logic [CPAM_CTRL_W-1:0] next_ctrl;
  logic [15:0] next_low_v;
  logic [15:0] next_max_i;
  logic [15:0] next_max_v;
  logic [15:0] next_max_t;
  cpam_meas_s next_meas_q;
  logic [CPAM_NCAUSE-1:0] next_cause;
  cpam_state_e next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [CPAM_NCAUSE-1:0] live;
  logic trip;
  logic wr_en;
  logic map_hit;
  logic reconnect_w;

  assign wr_en = psel && penable && pwrite && pready;
  assign map_hit = hit(paddr, CPAM_REG_CTRL) || hit(paddr, CPAM_REG_LOW_V)
    || hit(paddr, CPAM_REG_MAX_I) || hit(paddr, CPAM_REG_MAX_V)
    || hit(paddr, CPAM_REG_MAX_T) || hit(paddr, CPAM_REG_STATUS)
    || hit(paddr, CPAM_REG_MEAS_V) || hit(paddr, CPAM_REG_MEAS_I)
    || hit(paddr, CPAM_REG_MEAS_T);

  // ==========================================================
  // Live cause detection
  // ==========================================================
  // motor type unused
  // Motor type deliberately never enters these terms
  always_comb
  begin
    live = '0;
    live[0] = ctrl[CPAM_CTRL_LOWV_EN] && (meas_q.volt < low_v);
    live[1] = over_u(meas_q.volt, max_v);
    live[2] = over_u(meas_q.curr, max_i);
    live[3] = $signed(meas_q.temp) > $signed(max_t);
    live[4] = ctrl[CPAM_CTRL_DRV_OVH_EN] && drv.drv_overheat;
    live[5] = ctrl[CPAM_CTRL_HB_FAULT_EN] && drv.drv_fault;
    live[6] = ctrl[CPAM_CTRL_SWAP_EN] && drv.limit_swap;
  end

  assign trip = |live;

  // ==========================================================
  // Sample capture, causes and alarm state
  // ==========================================================
  always_comb
  begin
    next_meas_q = meas_q;
    next_cause = cause;
    next_state = state;
    if (sample_valid)
    begin
      next_meas_q = meas;
    end
    if (ctrl[CPAM_CTRL_STICKY])
    begin
      // Set wins: a live cause is never lost by the STOP clear
      if (stop_cmd)
      begin
        next_cause = live;
      end
      else
      begin
        next_cause = cause | live;
      end
    end
    else
    begin
      next_cause = live;
    end
    unique case (state)
      CPAM_RUN:
      begin
        if (trip)
        begin
          next_state = CPAM_ALARM;
        end
      end
      CPAM_ALARM:
      begin
        if (stop_cmd && !trip)
        begin
          next_state = CPAM_RUN;
        end
      end
      default:
      begin
        next_state = CPAM_ALARM;
      end
    endcase
  end

  // ==========================================================
  // Configuration writes
  // ==========================================================
  always_comb
  begin
    next_ctrl = ctrl;
    next_low_v = low_v;
    next_max_i = max_i;
    next_max_v = max_v;
    next_max_t = max_t;
    if (wr_en)
    begin
      if (hit(paddr, CPAM_REG_CTRL)) next_ctrl = pwdata[CPAM_CTRL_W-1:0];
      if (hit(paddr, CPAM_REG_LOW_V)) next_low_v = pwdata[15:0];
      if (hit(paddr, CPAM_REG_MAX_I)) next_max_i = pwdata[15:0];
      if (hit(paddr, CPAM_REG_MAX_V)) next_max_v = pwdata[15:0];
      if (hit(paddr, CPAM_REG_MAX_T)) next_max_t = pwdata[15:0];
    end
  end

  // ==========================================================
  // APB answer: one wait state, so every access takes three cycles
  // ==========================================================
  always_comb
  begin
    next_pready = psel && penable && !pready;
    next_pslverr = psel && penable && !pready && !map_hit;
    next_prdata = '0;
    if (psel && penable && !pready && !pwrite)
    begin
      unique case (paddr)
        CPAM_REG_CTRL: next_prdata = {26'h0, ctrl};
        CPAM_REG_LOW_V: next_prdata = {16'h0, low_v};
        CPAM_REG_MAX_I: next_prdata = {16'h0, max_i};
        CPAM_REG_MAX_V: next_prdata = {16'h0, max_v};
        CPAM_REG_MAX_T: next_prdata = {16'h0, max_t};
        CPAM_REG_STATUS: next_prdata = {22'h0, link_reconnect, alarm, 1'b0, cause};
        CPAM_REG_MEAS_V: next_prdata = {16'h0, meas_q.volt};
        CPAM_REG_MEAS_I: next_prdata = {16'h0, meas_q.curr};
        CPAM_REG_MEAS_T: next_prdata = {16'h0, meas_q.temp};
        default: next_prdata = '0;
      endcase
    end
  end

  // ==========================================================
  // State registers and registered outputs
  // ==========================================================
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= CPAM_CTRL_RST;
      low_v <= CPAM_LOW_V_RST;
      max_i <= CPAM_MAX_I_RST;
      max_v <= CPAM_MAX_V_RST;
      max_t <= CPAM_MAX_T_RST;
      meas_q <= '0;
      cause <= '0;
      state <= CPAM_RUN;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      alarm <= 1'b0;
      motion_halt <= 1'b0;
      winding_off <= 1'b0;
      ramp_bypass <= 1'b0;
      move_accept <= 1'b0;
      link_reconnect <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      low_v <= next_low_v;
      max_i <= next_max_i;
      max_v <= next_max_v;
      max_t <= next_max_t;
      meas_q <= next_meas_q;
      cause <= next_cause;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      alarm <= next_state == CPAM_ALARM;
      motion_halt <= next_state == CPAM_ALARM;
      winding_off <= next_state == CPAM_ALARM;
      ramp_bypass <= next_state == CPAM_ALARM;
      move_accept <= move_req && next_state == CPAM_RUN;
      link_reconnect <= reconnect_w;
    end
  end

  // ==========================================================
  // Link-loss recovery unit
  // ==========================================================
  // enable gates unit
  cpam_link_watch u_link
  (
    .mclk(mclk),
    .rst(rst),
    .enable(ctrl[CPAM_CTRL_LINK_RCV_EN]),
    .link_activity(link_activity),
    .reconnect(reconnect_w)
  );

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_trip_alarm;
    @(posedge mclk) disable iff (rst) trip |=> alarm && winding_off && motion_halt;
  endproperty
  a_trip_alarm: assert property (p_trip_alarm) else $error("trip did not alarm");

  property p_exit;
    @(posedge mclk) disable iff (rst) $fell(alarm) |-> $past(stop_cmd) && !$past(trip);
  endproperty
  a_exit: assert property (p_exit) else $error("alarm left without stop");

  property p_lowv;
    @(posedge mclk) disable iff (rst) !ctrl[CPAM_CTRL_LOWV_EN] && !cause[0] |=> !cause[0];
  endproperty
  a_lowv: assert property (p_lowv) else $error("undervoltage while disabled");

  property p_overi;
    @(posedge mclk) disable iff (rst) meas_q.curr > max_i |=> alarm;
  endproperty
  a_overi: assert property (p_overi) else $error("overcurrent missed");

  property p_overv;
    @(posedge mclk) disable iff (rst) meas_q.volt > max_v |=> alarm && cause[1];
  endproperty
  a_overv: assert property (p_overv) else $error("overvoltage missed");

  property p_follow;
    @(posedge mclk) disable iff (rst) !ctrl[CPAM_CTRL_STICKY] |=> cause == $past(live);
  endproperty
  a_follow: assert property (p_follow) else $error("cause not following");

  property p_link_off;
    @(posedge mclk) disable iff (rst) !ctrl[CPAM_CTRL_LINK_RCV_EN] [*2] |=> !link_reconnect;
  endproperty
  a_link_off: assert property (p_link_off) else $error("reconnect while disabled");

  property p_no_move;
    @(posedge mclk) disable iff (rst) alarm ##1 alarm |-> !move_accept;
  endproperty
  a_no_move: assert property (p_no_move) else $error("move accepted in alarm");

endmodule : cpam_monitor

`default_nettype wire

/* logic/cpam_pkg.sv */
/*
  Package for the critical parameter alarm monitor: register map,
  field positions, reset values, carrier structs and state encoding.
  Assumes a 32-bit APB slave and one 50 MHz system clock.
*/
package cpam_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] CPAM_REG_CTRL = 8'h00;
  localparam logic [7:0] CPAM_REG_LOW_V = 8'h04;
  localparam logic [7:0] CPAM_REG_MAX_I = 8'h08;
  localparam logic [7:0] CPAM_REG_MAX_V = 8'h0c;
  localparam logic [7:0] CPAM_REG_MAX_T = 8'h10;
  localparam logic [7:0] CPAM_REG_STATUS = 8'h14;
  localparam logic [7:0] CPAM_REG_MEAS_V = 8'h18;
  localparam logic [7:0] CPAM_REG_MEAS_I = 8'h1c;
  localparam logic [7:0] CPAM_REG_MEAS_T = 8'h20;

  // ==========================================================
  // Control register field positions
  // ==========================================================
  localparam int CPAM_CTRL_LOWV_EN = 0;
  localparam int CPAM_CTRL_DRV_OVH_EN = 1;
  localparam int CPAM_CTRL_HB_FAULT_EN = 2;
  localparam int CPAM_CTRL_SWAP_EN = 3;
  localparam int CPAM_CTRL_STICKY = 4;
  localparam int CPAM_CTRL_LINK_RCV_EN = 5;
  localparam int CPAM_CTRL_W = 6;

  // Status register field positions (cause bits 0..6)
  localparam int CPAM_ST_ALARM = 8;
  localparam int CPAM_ST_RECONNECT = 9;
  localparam int CPAM_NCAUSE = 7;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [5:0] CPAM_CTRL_RST = 6'h0e;
  localparam logic [15:0] CPAM_LOW_V_RST = 16'h0000;
  localparam logic [15:0] CPAM_MAX_I_RST = 16'hffff;
  localparam logic [15:0] CPAM_MAX_V_RST = 16'hffff;
  localparam logic [15:0] CPAM_MAX_T_RST = 16'h7fff;

  // ==========================================================
  // Link watchdog timing
  // ==========================================================
  localparam int CPAM_CLK_HZ = 50000000;
  localparam int CPAM_LINK_TIMEOUT_MS = 100;
  localparam int CPAM_LINK_TIMEOUT_CYC = CPAM_CLK_HZ / 1000 * CPAM_LINK_TIMEOUT_MS;
  localparam int CPAM_RECONNECT_MS = 10;
  localparam int CPAM_RECONNECT_CYC = CPAM_CLK_HZ / 1000 * CPAM_RECONNECT_MS;

  // ==========================================================
  // Carriers and states
  // ==========================================================
  typedef struct packed {
    logic [15:0] volt;  // Supply voltage, 10 mV units
    logic [15:0] curr;  // Supply current, mA
    logic [15:0] temp;  // Processor temperature, 0.1 degC signed
  } cpam_meas_s;

  typedef struct packed {
    logic drv_overheat;  // Driver near critical temperature
    logic drv_fault;     // Power stage fault
    logic limit_swap;    // Wrong limit switch for direction
  } cpam_drv_s;

  typedef enum logic [1:0] {
    CPAM_RUN = 2'b01,
    CPAM_ALARM = 2'b10
  } cpam_state_e;

endpackage : cpam_pkg

/* logic/cpam_link_watch.sv */
/*
  Link-loss watchdog: counts idle cycles since the last link activity
  and, when enabled, pulses a reconnect request window.
  Assumes link_activity is a synchronous one-cycle pulse per packet.
*/
`timescale 1ns/1ps
`default_nettype none

module cpam_link_watch
  import cpam_pkg::*;
#(
  parameter int TIMEOUT_CYC = CPAM_LINK_TIMEOUT_CYC,
  parameter int RECONNECT_CYC = CPAM_RECONNECT_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic link_activity,
  output logic reconnect
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_reconnect;

  // ==========================================================
  // Idle counter and reconnect window
  // ==========================================================
  // Disabled unit is held idle so it never asserts reconnect
  always_comb
  begin
    next_cnt = cnt;
    next_reconnect = reconnect;
    if (!enable || link_activity)
    begin
      next_cnt = '0;
      next_reconnect = 1'b0;
    end
    else if (reconnect)
    begin
      // Hold the bus-reset window, then restart the idle count
      if (cnt >= 32'(RECONNECT_CYC - 1))
      begin
        next_cnt = '0;
        next_reconnect = 1'b0;
      end
      else
      begin
        next_cnt = cnt + 32'd1;
      end
    end
    else if (cnt >= 32'(TIMEOUT_CYC - 1))
    begin
      next_cnt = '0;
      next_reconnect = 1'b1;
    end
    else
    begin
      next_cnt = cnt + 32'd1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= '0;
      reconnect <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      reconnect <= next_reconnect;
    end
  end

endmodule : cpam_link_watch

`default_nettype wire

/* testbench/cpam_drv_model.sv */
/*
  Far-side model: measurement front end and power driver status lines.
  Assumes the bench sets the analog values and driver flags it wants.
*/
`timescale 1ns/1ps
`default_nettype none

module cpam_drv_model
  import cpam_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire cpam_meas_s meas_set,
  input wire cpam_drv_s drv_set,
  output logic sample_valid,
  output cpam_meas_s meas,
  output cpam_drv_s drv
);
  logic [1:0] phase;

  // ==========================================================
  // Sampling
  // ==========================================================
  // One conversion every four cycles; off-strobe the bus is inverted
  // so that a capture on the wrong cycle cannot pass by luck
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      phase <= 2'h0;
      sample_valid <= 1'b0;
      meas <= '0;
      drv <= '0;
    end
    else
    begin
      phase <= phase + 2'h1;
      sample_valid <= (phase == 2'h3);
      meas <= (phase == 2'h3) ? meas_set : cpam_meas_s'(~meas_set);
      drv <= drv_set;  // Driver flags are levels
    end
  end
endmodule : cpam_drv_model
`default_nettype wire

/* testbench/testbench.sv */
/*
  Self-checking bench for the alarm monitor: APB register, limit,
  driver input, sticky flag and move blocking scenarios.
  Assumes the far-side model delivers a sample every four cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import cpam_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, stop_cmd, move_req, motor_is_dc, link_activity;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sample_valid, move_accept, motion_halt;
  logic winding_off, ramp_bypass, alarm, link_reconnect;
  cpam_meas_s meas, meas_set;
  cpam_drv_s drv, drv_set;
  int err_count = 0;
  int comparisons = 0;

  always #10 mclk = ~mclk;

  cpam_monitor dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motor_is_dc(motor_is_dc),
    .sample_valid(sample_valid), .meas(meas), .drv(drv), .stop_cmd(stop_cmd),
    .move_req(move_req), .link_activity(link_activity), .move_accept(move_accept),
    .motion_halt(motion_halt), .winding_off(winding_off),
    .ramp_bypass(ramp_bypass), .alarm(alarm), .link_reconnect(link_reconnect));

  // Short watchdog spans so the recovery unit shows up in a short run
  defparam dut.u_link.TIMEOUT_CYC = 20;
  defparam dut.u_link.RECONNECT_CYC = 5;

  cpam_drv_model far_side (.mclk(mclk), .rst(rst), .meas_set(meas_set),
    .drv_set(drv_set), .sample_valid(sample_valid), .meas(meas), .drv(drv));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t ns %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Request held until pready is sampled high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Look just after each edge; a high pready then stands until the
    // next edge, where the slave samples it and the transfer completes
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      chk(32'h0, 32'h1, "apb answer");
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(rd, exp, what);
  endtask : rdc

  // Alarm group: {alarm, motion_halt, winding_off, ramp_bypass}
  task automatic wait_chk(input int n, input logic [3:0] exp, input string what);
    repeat (n) @(posedge mclk);
    #1;
    chk({28'h0, alarm, motion_halt, winding_off, ramp_bypass}, {28'h0, exp}, what);
  endtask : wait_chk

  task automatic stop;
    @(posedge mclk);
    stop_cmd <= 1'b1;
    @(posedge mclk);
    stop_cmd <= 1'b0;
  endtask : stop

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_regs;
    logic e;
    rdc(CPAM_REG_CTRL, 32'h0000000e, "ctrl reset");
    rdc(CPAM_REG_LOW_V, 32'h00000000, "low_v reset");
    rdc(CPAM_REG_MAX_I, 32'h0000ffff, "max_i reset");
    rdc(CPAM_REG_MAX_V, 32'h0000ffff, "max_v reset");
    rdc(CPAM_REG_MAX_T, 32'h00007fff, "max_t reset");
    wr(CPAM_REG_STATUS, 32'h000001ff);
    rdc(CPAM_REG_STATUS, 32'h00000000, "status read only");
    rdc(CPAM_REG_MEAS_V, {16'h0, meas_set.volt}, "last sample");
    apb(1'b0, 8'h24, 32'h0, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    $display("test registers done");
  endtask : t_regs

  task automatic t_limits(input logic dc);
    logic [7:0] ad [4] = '{CPAM_REG_LOW_V, CPAM_REG_MAX_V, CPAM_REG_MAX_I, CPAM_REG_MAX_T};
    logic [15:0] trip [4] = '{16'h0bb8, 16'h07d0, 16'h0190, 16'h00c8};
    logic [15:0] back [4] = '{16'h0000, 16'hffff, 16'hffff, 16'h7fff};
    motor_is_dc <= dc;
    wr(CPAM_REG_CTRL, 32'h0000000e);
    wr(CPAM_REG_LOW_V, 32'h00000bb8);
    wait_chk(10, 4'h0, "low supply with check off");
    wr(CPAM_REG_LOW_V, 32'h00000000);
    wr(CPAM_REG_CTRL, 32'h0000000f);
    for (int i = 0; i < 4; i++)
    begin
      wr(ad[i], {16'h0, trip[i]});
      wait_chk(10, 4'hf, "limit trips alarm");
      rdc(CPAM_REG_STATUS, 32'h100 | (32'h1 << i), "limit cause");
      stop();
      wait_chk(4, 4'hf, "stop with live cause");
      wr(ad[i], {16'h0, back[i]});
      stop();
      wait_chk(3, 4'h0, "stop after recovery");
      rdc(CPAM_REG_STATUS, 32'h0, "status clear");
    end
    $display("test limits done");
  endtask : t_limits

  task automatic t_drv;
    for (int i = 0; i < 3; i++)
    begin
      wr(CPAM_REG_CTRL, 32'h0e & ~(32'h2 << i));
      drv_set <= cpam_drv_s'(3'b100 >> i);
      move_req <= 1'b1;
      wait_chk(6, 4'h0, "driver cause masked");
      chk({31'h0, move_accept}, 32'h1, "move accepted");
      wr(CPAM_REG_CTRL, 32'h0000000e);
      wait_chk(4, 4'hf, "driver cause alarms");
      chk({31'h0, move_accept}, 32'h0, "move blocked");
      rdc(CPAM_REG_STATUS, 32'h100 | (32'h10 << i), "driver cause");
      drv_set <= '0;
      rdc(CPAM_REG_STATUS, 32'h100, "cause follows source");
      stop();
      wait_chk(3, 4'h0, "driver alarm cleared");
    end
    @(posedge mclk);
    move_req <= 1'b0;
    $display("test driver done");
  endtask : t_drv

  task automatic t_sticky;
    wr(CPAM_REG_CTRL, 32'h0000001e);
    drv_set <= 3'b010;
    repeat (3) @(posedge mclk);
    drv_set <= '0;
    wait_chk(4, 4'hf, "short fault alarms");
    rdc(CPAM_REG_STATUS, 32'h120, "cause latched");
    stop();
    wait_chk(3, 4'h0, "stop clears alarm");
    rdc(CPAM_REG_STATUS, 32'h0, "latched cause cleared");
    chk({31'h0, link_reconnect}, 32'h0, "recovery idle when off");
    $display("test sticky done");
  endtask : t_sticky

  // Idle timeout of 20 cycles, then a 5 cycle reconnect window
  task automatic t_link;
    wr(CPAM_REG_CTRL, 32'h0000002e);
    repeat (20) @(posedge mclk);
    #1;
    chk({31'h0, link_reconnect}, 32'h0, "no reconnect before timeout");
    @(posedge mclk);
    #1;
    chk({31'h0, link_reconnect}, 32'h1, "reconnect after idle timeout");
    @(posedge mclk);
    link_activity <= 1'b1;
    @(posedge mclk);
    link_activity <= 1'b0;
    @(posedge mclk);
    #1;
    chk({31'h0, link_reconnect}, 32'h0, "activity ends reconnect");
    wr(CPAM_REG_CTRL, 32'h0000000e);
    // Lands inside the window that an ungated unit would open
    repeat (18) @(posedge mclk);
    #1;
    chk({31'h0, link_reconnect}, 32'h0, "recovery off stays idle");
    $display("test link done");
  endtask : t_link

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial
  begin
    {psel, penable, pwrite, stop_cmd, move_req, motor_is_dc, link_activity} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    meas_set = '{volt: 16'h0960, curr: 16'h01f4, temp: 16'h012c};
    drv_set = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_limits(1'b0);
    t_limits(1'b1);
    t_drv();
    t_sticky();
    t_link();
    end_of_test();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
